// >>> pkg/aets_pkg.sv
// Constants and types for the second converter's event trigger select block.
// Assumes one peripheral clock and an AXI4-Lite register bus with 32-bit data.
package aets_pkg;

  // Register byte offsets.
  localparam logic [3:0] MUX_CTRL_OFFS = 4'h0;
  localparam logic [3:0] SRC_SEL_OFFS = 4'h4;
  localparam logic [3:0] STATUS_OFFS = 4'h8;

  // Values after reset.
  localparam logic [1:0] MUX_CTRL_RST = 2'h1;
  localparam logic [11:0] SRC_SEL_RST = 12'h000;

  // Field positions in the multiplexing control register.
  localparam int MUX_DEFAULT_BIT = 0;
  localparam int MUX_ALT_BIT = 1;

  // Field positions in the source select register.
  localparam int EVT_SEL_LSB = 0;
  localparam int EVT_EN_BIT = 3;
  localparam int G1_SEL_LSB = 4;
  localparam int G1_EN_BIT = 7;
  localparam int G2_SEL_LSB = 8;
  localparam int G2_EN_BIT = 11;

  // Field positions in the status register.
  localparam int STAT_ALT_BIT = 0;
  localparam int STAT_TRIG_LSB = 4;

  // Timer channel taps of the default hookup.
  localparam int DEF_T1_CH_A = 8;
  localparam int DEF_T1_CH_B = 10;
  localparam int DEF_T1_CH_C = 12;
  localparam int DEF_T1_CH_D = 14;

  // Timer channel taps of the alternate hookup.
  localparam int ALT_T2_CH_A = 5;
  localparam int ALT_T1_CH_B = 27;
  localparam int ALT_T1_CH_C = 17;
  localparam int ALT_T1_CH_D = 19;
  localparam int ALT_T1_CH_E = 11;
  localparam int ALT_T2_CH_F = 13;

  // Source select codes.
  localparam logic [2:0] SRC_PIN = 3'h0;
  localparam logic [2:0] SRC_PIT = 3'h3;
  localparam logic [2:0] SRC_CODE6 = 3'h6;
  localparam logic [2:0] SRC_CODE7 = 3'h7;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One conversion group's trigger configuration.
  typedef struct packed {
    logic enable;
    logic [2:0] source_sel;
  } aets_grp_cfg_t;

  // All three groups: event group, group 1, group 2.
  typedef struct packed {
    aets_grp_cfg_t group2_trigger_source_sel;
    aets_grp_cfg_t group1_trigger_source_sel;
    aets_grp_cfg_t event_group_trigger_source_sel;
  } aets_src_sel_t;

endpackage

// >>> rtl/aets_trigger_select.sv
// Event trigger selection for the second converter's three conversion groups.
// Assumes timer and periodic interrupt timer outputs run on i_core_clk; pin inputs
// are asynchronous and come from the output side of the pad input buffers.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.

// Operation
// - Alternate hookup: code 110 picks timer one ch 11, 111 timer two ch 13.
// - Alternate codes 000..101: pin, t2 ch5, t1 ch27, compare 0, t1 ch17, ch19.
// - Each of three groups has its own 3-bit select among eight sources.
// - Bits 0 and 1 of the mux control register choose the hookup.
// - Bit 0 set selects the default hookup regardless of bit 1.
// - Bit 0 clear and bit 1 set selects the alternate hookup.
// - Event pin is taken after the pad input buffer, input or output use.
// - Timer sources are tapped at the timer boundary, before pad output buffers.
// - Compare 0 comes straight from the timer module, not the processor interrupt.
module aets_trigger_select
  import aets_pkg::*;
#(
  parameter int T1_CH = 32,
  parameter int T2_CH = 20
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // AXI4-Lite write address and data.
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [3:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response.
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read.
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [3:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Trigger sources.
  input wire logic i_converter2_event_pin,
  input wire logic [1:0] i_gpio_b_pin,
  input wire logic [T1_CH-1:0] i_timer_module_one,
  input wire logic [T2_CH-1:0] i_timer_module_two,
  input wire logic i_pit_compare0,
  // Triggers to the converter and hookup state.
  output logic o_event_group_trig,
  output logic o_group1_trig,
  output logic o_group2_trig,
  output logic o_alt_hookup
);

  function automatic logic pick(input logic [2:0] code, input logic [7:0] srcs);
    pick = srcs[code];
  endfunction

  function automatic logic [1:0] resp_for(input logic [3:0] addr);
    resp_for = (addr == MUX_CTRL_OFFS || addr == SRC_SEL_OFFS || addr == STATUS_OFFS)
      ? RESP_OKAY : RESP_SLVERR;
  endfunction

  logic [1:0] pin_sync_ff, nxt_pin_sync;
  logic [1:0] gio_s0_ff, nxt_gio_s0;
  logic [1:0] gio_s1_ff, nxt_gio_s1;
  logic [1:0] mux_ctrl_ff, nxt_mux_ctrl;
  aets_src_sel_t src_sel_ff, nxt_src_sel;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [3:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [2:0] trig_ff, nxt_trig;
  logic alt_ff, nxt_alt;
  logic alt_sel;
  logic [7:0] def_srcs;
  logic [7:0] alt_srcs;
  logic [7:0] srcs;
  logic [11:0] sel_flat;
  logic [31:0] rd_word;

  // Pad inputs pass two flip-flops before anything reads them.
  always_comb
  begin
    nxt_pin_sync = {pin_sync_ff[0], i_converter2_event_pin};
    nxt_gio_s0 = i_gpio_b_pin;
    nxt_gio_s1 = gio_s0_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_sync_ff <= 2'h0;
      gio_s0_ff <= 2'h0;
      gio_s1_ff <= 2'h0;
    end
    else
    begin
      pin_sync_ff <= nxt_pin_sync;
      gio_s0_ff <= nxt_gio_s0;
      gio_s1_ff <= nxt_gio_s1;
    end
  end

  // Hookup choice; bit 0 wins, and both bits clear fall back to the default.
  always_comb
  begin
    alt_sel = !mux_ctrl_ff[MUX_DEFAULT_BIT] &&
      mux_ctrl_ff[MUX_ALT_BIT];
  end

  // Source tables in code order. Timer taps are the module outputs themselves.
  always_comb
  begin
    def_srcs = {gio_s1_ff[1], gio_s1_ff[0], i_timer_module_one[DEF_T1_CH_D],
                i_timer_module_one[DEF_T1_CH_C], i_pit_compare0,
                i_timer_module_one[DEF_T1_CH_B], i_timer_module_one[DEF_T1_CH_A],
                pin_sync_ff[1]};
    alt_srcs = {i_timer_module_two[ALT_T2_CH_F], i_timer_module_one[ALT_T1_CH_E],
                i_timer_module_one[ALT_T1_CH_D], i_timer_module_one[ALT_T1_CH_C],
                i_pit_compare0, i_timer_module_one[ALT_T1_CH_B],
                i_timer_module_two[ALT_T2_CH_A], pin_sync_ff[1]};
    srcs = alt_sel ? alt_srcs : def_srcs;
  end

  // Each group keeps its own select and enable.
  always_comb
  begin
    nxt_trig[0] = src_sel_ff.event_group_trigger_source_sel.enable &&
      pick(src_sel_ff.event_group_trigger_source_sel.source_sel, srcs);
    nxt_trig[1] = src_sel_ff.group1_trigger_source_sel.enable &&
      pick(src_sel_ff.group1_trigger_source_sel.source_sel, srcs);
    nxt_trig[2] = src_sel_ff.group2_trigger_source_sel.enable &&
      pick(src_sel_ff.group2_trigger_source_sel.source_sel, srcs);
    nxt_alt = alt_sel;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      trig_ff <= 3'h0;
      alt_ff <= 1'b0;
    end
    else
    begin
      trig_ff <= nxt_trig;
      alt_ff <= nxt_alt;
    end
  end

  assign o_event_group_trig = trig_ff[0];
  assign o_group1_trig = trig_ff[1];
  assign o_group2_trig = trig_ff[2];
  assign o_alt_hookup = alt_ff;

  // Bus slave: address and data are taken in either order, then one response.
  assign o_awready = !aw_got_ff && !bvalid_ff;
  assign o_wready = !w_got_ff && !bvalid_ff;
  assign o_arready = !rvalid_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  always_comb
  begin
    sel_flat = src_sel_ff;
    rd_word = 32'h0000_0000;
    unique case (i_araddr)
      MUX_CTRL_OFFS: rd_word[1:0] = mux_ctrl_ff;
      SRC_SEL_OFFS: rd_word[11:0] = sel_flat;
      STATUS_OFFS:
      begin
        rd_word[STAT_ALT_BIT] = alt_ff;
        rd_word[STAT_TRIG_LSB +: 3] = trig_ff;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_mux_ctrl = mux_ctrl_ff;
    nxt_src_sel = src_sel_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (i_awvalid && o_awready)
    begin
      nxt_aw_got = 1'b1;
      nxt_waddr = i_awaddr;
    end
    if (i_wvalid && o_wready)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = i_wdata;
      nxt_wstrb = i_wstrb;
    end
    if (aw_got_ff && w_got_ff)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = resp_for(waddr_ff);
      if (waddr_ff == MUX_CTRL_OFFS && wstrb_ff[0])
        nxt_mux_ctrl = wdata_ff[1:0];
      if (waddr_ff == SRC_SEL_OFFS)
      begin
        if (wstrb_ff[0])
          nxt_src_sel[7:0] = wdata_ff[7:0];
        if (wstrb_ff[1])
          nxt_src_sel[11:8] = wdata_ff[11:8];
      end
    end
    if (bvalid_ff && i_bready)
      nxt_bvalid = 1'b0;
    if (i_arvalid && o_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_word;
      nxt_rresp = resp_for(i_araddr);
    end
    else if (rvalid_ff && i_rready)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      mux_ctrl_ff <= MUX_CTRL_RST;
      src_sel_ff <= SRC_SEL_RST;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      mux_ctrl_ff <= nxt_mux_ctrl;
      src_sel_ff <= nxt_src_sel;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  a_alt_code_six: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (alt_sel && src_sel_ff.group1_trigger_source_sel == {1'b1, SRC_CODE6})
    |=> o_group1_trig == $past(i_timer_module_one[ALT_T1_CH_E]))
    else $error("Alternate code 6 does not follow timer one channel 11.");

  a_alt_code_seven: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (alt_sel && src_sel_ff.group2_trigger_source_sel == {1'b1, SRC_CODE7})
    |=> o_group2_trig == $past(i_timer_module_two[ALT_T2_CH_F]))
    else $error("Alternate code 7 does not follow timer two channel 13.");

  a_alt_code_one: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (alt_sel && src_sel_ff.event_group_trigger_source_sel == 4'h9)
    |=> o_event_group_trig == $past(i_timer_module_two[ALT_T2_CH_A]))
    else $error("Alternate code 1 does not follow timer two channel 5.");

  a_group_disabled: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    !src_sel_ff.group1_trigger_source_sel.enable |=> !o_group1_trig)
    else $error("Disabled group 1 raised a trigger.");

  a_mux_write_hookup: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (aw_got_ff && w_got_ff && waddr_ff == MUX_CTRL_OFFS && wstrb_ff[0] && wdata_ff[1:0] == 2'h2)
    |=> ##1 o_alt_hookup)
    else $error("Writing 2 to mux control did not select the alternate hookup.");

  a_default_wins: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    mux_ctrl_ff[MUX_DEFAULT_BIT] |=> !o_alt_hookup)
    else $error("Alternate hookup active with default bit set.");

  a_alt_chosen: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (mux_ctrl_ff == 2'h2) |=> o_alt_hookup)
    else $error("Alternate hookup not active for mux value 2.");

  a_pin_trigger: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (src_sel_ff.event_group_trigger_source_sel == {1'b1, SRC_PIN} && i_converter2_event_pin)
    [*4] |-> o_event_group_trig)
    else $error("Held event pin did not trigger within three cycles.");

  a_pit_trigger: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (src_sel_ff.group2_trigger_source_sel == {1'b1, SRC_PIT})
    |=> o_group2_trig == $past(i_pit_compare0))
    else $error("Compare 0 trigger not passed to group 2.");

  a_fallback_default: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (mux_ctrl_ff == 2'h0 && src_sel_ff.group1_trigger_source_sel == 4'h9)
    |=> o_group1_trig == $past(i_timer_module_one[DEF_T1_CH_A]))
    else $error("Both mux bits clear did not fall back to the default hookup.");

endmodule

// >>> verification/aets_src_model.sv
// Far-side model: both timer modules, the periodic timer compare output and the pads.
// Assumes every source changes just after the rising edge of the core clock.
module aets_src_model
(
  // Clock.
  input wire logic i_core_clk,
  // Trigger sources.
  output logic [31:0] o_t1,
  output logic [19:0] o_t2,
  output logic o_pit,
  output logic o_pin,
  output logic [1:0] o_gpio
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_core_clk)
  begin
    o_t1 <= $urandom;
    o_t2 <= 20'($urandom);
    o_pit <= 1'($urandom);
    o_pin <= 1'($urandom);
    o_gpio <= 2'($urandom);
  end
endmodule

// >>> verification/tb_adc2_event_trigger_select.sv
// Self-checking bench for the second converter's event trigger select block.
// Assumes the package and the far-side source model are compiled first.
module tb_adc2_event_trigger_select
  import aets_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, aw_rdy, w_rdy, bvalid, ar_rdy;
  logic rvalid, pit, pin, ev_trig, g1_trig, g2_trig, alt, pit_q;
  logic [3:0] awaddr, araddr, wstrb;
  logic [1:0] bresp, rresp, gpio, mux_m;
  logic [31:0] wdata, rdata, t1, t1_q;
  logic [19:0] t2, t2_q;
  logic [2:0] p1, p2, p3;
  logic [11:0] sel_m;
  int fail_count, compares;

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  aets_trigger_select aets_trigger_select_inst (.i_core_clk(clk), .i_resetn(rst_n),
    .i_awvalid(awvalid), .o_awready(aw_rdy), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(w_rdy), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(ar_rdy), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_converter2_event_pin(pin), .i_gpio_b_pin(gpio), .i_timer_module_one(t1),
    .i_timer_module_two(t2), .i_pit_compare0(pit), .o_event_group_trig(ev_trig),
    .o_group1_trig(g1_trig), .o_group2_trig(g2_trig), .o_alt_hookup(alt));

  aets_src_model aets_src_model_inst (.i_core_clk(clk), .o_t1(t1), .o_t2(t2), .o_pit(pit),
    .o_pin(pin), .o_gpio(gpio));

  // Timer sources show one edge later, pad sources three edges later.
  always @(posedge clk)
  begin
    t1_q <= t1;
    t2_q <= t2;
    pit_q <= pit;
    p1 <= {gpio, pin};
    p2 <= p1;
    p3 <= p2;
  end

  function automatic logic src(input logic [2:0] c, input logic a);
    case (c)
      3'h0: src = p3[0];
      3'h1: src = a ? t2_q[5] : t1_q[8];
      3'h2: src = a ? t1_q[27] : t1_q[10];
      3'h3: src = pit_q;
      3'h4: src = a ? t1_q[17] : t1_q[12];
      3'h5: src = a ? t1_q[19] : t1_q[14];
      3'h6: src = a ? t1_q[11] : p3[1];
      default: src = a ? t2_q[13] : p3[2];
    endcase
  endfunction

  // Mapped offsets answer OKAY, every other offset SLVERR.
  function automatic logic [1:0] exp_resp(input logic [3:0] a);
    exp_resp = (a == MUX_CTRL_OFFS || a == SRC_SEL_OFFS || a == STATUS_OFFS) ?
      RESP_OKAY : RESP_SLVERR;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && aw_rdy) awvalid <= 1'h0;
      if (wvalid && w_rdy) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'h0;
    chk("write bresp", 32'(exp_resp(a)), 32'(r));
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && ar_rdy) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    chk("read rresp", 32'(exp_resp(a)), 32'(r));
  endtask

  task automatic results;
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] e;
    logic a;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    rst_n = 1'h0;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'h40d7));
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    rd(MUX_CTRL_OFFS, d, r);
    chk("mux reset", 32'h0000_0001, d);
    rd(SRC_SEL_OFFS, d, r);
    chk("select reset", 32'h0000_0000, d);
    rd(4'hc, d, r);
    chk("unmapped read", 32'h0000_0000, d);
    chk("unmapped rresp", 32'h0000_0002, 32'(r));
    wr(4'hc, $urandom, r);
    chk("unmapped bresp", 32'h0000_0002, 32'(r));
    for (int m = 0; m < 4; m++)
    begin
      mux_m = 2'(m);
      a = (mux_m == 2'h2);
      wr(MUX_CTRL_OFFS, {30'h0, mux_m}, r);
      rd(STATUS_OFFS, d, r);
      chk("status alt", 32'(a), 32'(d[0]));
      for (int c = 0; c < 8; c++)
      begin
        e = (c > 4 && c[0]) ? 3'($urandom) : 3'h7;
        sel_m = {e[2], 3'(c + 5), e[1], 3'(c + 3), e[0], 3'(c)};
        wr(SRC_SEL_OFFS, {20'h0, sel_m}, r);
        rd(SRC_SEL_OFFS, d, r);
        chk("select readback", {20'h0, sel_m}, d);
        repeat (4) @(posedge clk);
        repeat (12)
        begin
          @(negedge clk);
          chk("alt hookup", 32'(a), 32'(alt));
          chk("event trig", 32'(sel_m[3] & src(sel_m[2:0], a)), 32'(ev_trig));
          chk("g1 trig", 32'(sel_m[7] & src(sel_m[6:4], a)), 32'(g1_trig));
          chk("g2 trig", 32'(sel_m[11] & src(sel_m[10:8], a)), 32'(g2_trig));
        end
      end
    end
    // Only byte lane 0 of the select register may change under a lane 0 strobe.
    @(posedge clk);
    wstrb <= 4'h1;
    wr(SRC_SEL_OFFS, 32'h0000_0fff, r);
    wstrb <= 4'hf;
    rd(SRC_SEL_OFFS, d, r);
    chk("select lane 0", {20'h0, sel_m[11:8], 8'hff}, d);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(MUX_CTRL_OFFS, d, r);
    chk("mux after reset", 32'h0000_0001, d);
    results();
  end
endmodule
